// ### bus_master_model.sv
// behavioural two-wire bus master facing the slave port
// assumes open-drain lines resolved outside with pull-ups
`timescale 1ns/10ps
`default_nettype none
module bus_master_model (
  input wire logic clk,      // bench clock, paces the bus
  input wire logic scl_line, // resolved clock line
  input wire logic sda_line, // resolved data line
  output logic scl_drv,      // 0 pulls clock low
  output logic sda_drv       // 0 pulls data low
);
  // ********
  // bus phases
  // ********
  // both lines released at rest, clock still outside frames
  initial begin
    scl_drv = 1'b1; // idle both high
    sda_drv = 1'b1;
  end

  // wait whole bench cycles
  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start; inside a frame release data first
  task automatic start();
    if (sda_line !== 1'b1 || scl_line !== 1'b1) begin
      scl_drv = 1'b0;
      pause(1);
      sda_drv = 1'b1; // release before raising clock
      pause(5);
      scl_drv = 1'b1;
    end
    pause(4);
    sda_drv = 1'b0; // data falls, clock high
    pause(4);
  endtask

  // stop: data rises while clock high
  task automatic stop();
    scl_drv = 1'b0;
    pause(1);
    sda_drv = 1'b0;
    pause(5);
    scl_drv = 1'b1;
    pause(4);
    sda_drv = 1'b1; // data rises, clock high
    pause(8);
  endtask

  // one clock pulse, 6 low then 2 high, slave may stretch
  task automatic bit_cycle(input logic b, output logic r);
    int n;
    scl_drv = 1'b0;
    pause(1);
    sda_drv = b; // data moves only with clock low
    pause(5);
    scl_drv = 1'b1;
    pause(1);
    n = 0;
    while (scl_line !== 1'b1 && n < 4000) begin
      pause(1);
      n++;
    end
    pause(n > 0 ? 2 : 1); // full high phase even after a stretch
    r = sda_line; // sampled late in the high phase
  endtask

  // byte to the slave, then the ninth clock
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], r); // msb first
    end
    bit_cycle(1'b1, r); // master clocks the ack
    ack = ~r; // ack is a low level
  endtask

  // byte from the slave, then ack or withheld ack
  task automatic recv_byte(input logic give_ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      d[i] = r;
    end
    bit_cycle(~give_ack, r); // last byte unacked
  endtask
endmodule
`default_nettype wire

// ### pin_filter.sv
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output moves once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module pin_filter #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk,              // system clock
  input wire logic rst,              // async reset, high
  input wire logic [WIDTH-1:0] pin,  // raw pins
  output logic [WIDTH-1:0] level     // filtered levels
);

  // ******************************************************
  // per-pin chain
  // ******************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      logic s1;
      logic s2;
      logic s3;
      // first stage feeds only the second
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1 <= INIT[i];
          s2 <= INIT[i];
          s3 <= INIT[i];
          level[i] <= INIT[i];
        end else begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            level[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### rtc_port_pkg.sv
// constants and types shared by the two-wire slave port files
// assumes a 50 MHz system clock and eight byte-wide calendar locations
package rtc_port_pkg;

  // ******************************************************
  // bus framing
  // ******************************************************
  localparam logic [6:0] DEV_ADDR = 7'h68;   // byte form d0h with rw 0
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int NUM_REGS = 8;
  localparam int PTR_W = 3;

  // ******************************************************
  // reset values
  // ******************************************************
  localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
  localparam logic [7:0] CLOCK_REG_RESET = 8'h00;
  localparam logic [7:0] CONTROL_REG_RESET = 8'h80;
  localparam logic [PTR_W-1:0] CONTROL_INDEX = 3'h7;
  localparam logic [1:0] PIN_RESET = 2'h3;   // lines idle high

  // ******************************************************
  // update stream buffer
  // ******************************************************
  localparam int UPD_W = PTR_W + 8;
  localparam int UPD_DEPTH = 8;

  // ******************************************************
  // port sequencer states
  // ******************************************************
  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_addr = 8'h02,
    st_ack = 8'h04,
    st_rx = 8'h08,
    st_hold = 8'h10,
    st_tx = 8'h20,
    st_mack = 8'h40,
    st_skip = 8'h80
  } state_type;

endpackage

// ### rtc_two_wire_slave_port.sv
// two-wire slave port with eight byte calendar locations and update stream
// assumes raw bus pins from outside, open-drain pads resolved outside
`timescale 1ns/10ps
`default_nettype none
module rtc_two_wire_slave_port
  import rtc_port_pkg::*;
(
  input wire logic clk,               // 50 mhz system clock
  input wire logic rst,               // async reset, high
  input wire logic scl_in,            // clock line level
  output logic scl_out,               // clock line drive value
  output logic scl_oe_n,              // low while holding clock
  input wire logic sda_in,            // data line level
  output logic sda_out,               // data line drive value
  output logic sda_oe_n,              // low while driving data
  output logic upd_valid,             // written byte waiting
  input wire logic upd_ready,         // consumer takes byte
  output logic [PTR_W-1:0] upd_addr,  // location written
  output logic [7:0] upd_data,        // byte written
  output logic [8*NUM_REGS-1:0] reg_image // all locations
);

  logic [1:0] level;
  logic scl_f;
  logic sda_f;
  logic scl_p;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  state_type state;
  logic [3:0] cnt;
  logic [7:0] rxsh;
  logic [7:0] txsh;
  logic rw;
  logic waddr_phase;
  logic acked;
  logic [PTR_W-1:0] ptr;
  logic [7:0] regs [NUM_REGS];
  logic byte_end;
  logic addr_done;
  logic addr_match;
  logic rx_done;
  logic wload;
  logic wr_now;
  logic rd_next;
  logic rd_stop;
  logic [PTR_W-1:0] tx_ptr;
  logic fifo_ready;

  // ******************************************************
  // pin synchronisers and bus condition decode
  // ******************************************************
  pin_filter #(.WIDTH(2), .INIT(PIN_RESET)) u_pins (
    .clk(clk),
    .rst(rst),
    .pin({scl_in, sda_in}),
    .level(level)
  );
  assign scl_f = level[1];
  assign sda_f = level[0];

  // previous filtered levels for edge finding
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_f;
      sda_p <= sda_f;
    end
  end

  // start and stop outrank data while clock high
  assign scl_rise = scl_f & ~scl_p;
  assign scl_fall = ~scl_f & scl_p;
  assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
  assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;

  // ******************************************************
  // byte boundary decisions
  // ******************************************************
  assign byte_end = scl_fall && cnt == BITS_PER_BYTE;
  assign addr_done = state == st_addr && byte_end;
  assign addr_match = rxsh[7:1] == DEV_ADDR;
  assign rx_done = state == st_rx && byte_end;
  assign wload = rx_done && waddr_phase;
  assign wr_now = (rx_done && !waddr_phase && fifo_ready) ||
                  (state == st_hold && fifo_ready);
  assign rd_next = state == st_mack && scl_fall && acked;
  assign rd_stop = state == st_mack && scl_fall && !acked;
  // read byte source: next location once the master has acked
  assign tx_ptr = rd_next ? ptr + 3'h1 : ptr;

  // ******************************************************
  // sequencer state and bit count
  // ******************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      cnt <= 4'h0;
      rw <= 1'b0;
      waddr_phase <= 1'b0;
    end else if (start_ev) begin
      state <= st_addr;
      cnt <= 4'h0;
    end else if (stop_ev) begin
      state <= st_idle;
      cnt <= 4'h0;
    end else begin
      if (scl_rise) begin
        cnt <= cnt + 4'h1;
      end
      case (state)
        st_idle: begin
          cnt <= 4'h0;
        end
        st_addr: begin
          if (addr_done) begin
            cnt <= 4'h0;
            rw <= rxsh[0];
            waddr_phase <= ~rxsh[0];
            state <= addr_match ? st_ack : st_skip;
          end
        end
        st_ack: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            state <= rw ? st_tx : st_rx;
          end
        end
        st_rx: begin
          if (rx_done) begin
            cnt <= 4'h0;
            waddr_phase <= 1'b0;
            state <= (waddr_phase || fifo_ready) ? st_ack : st_hold;
          end
        end
        st_hold: begin
          if (fifo_ready) begin
            state <= st_ack;
          end
        end
        st_tx: begin
          if (byte_end) begin
            cnt <= 4'h0;
            state <= st_mack;
          end
        end
        st_mack: begin
          if (scl_fall) begin
            cnt <= 4'h0;
            state <= acked ? st_tx : st_skip;
          end
        end
        st_skip: begin
          cnt <= 4'h0;
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // ******************************************************
  // receive shifter and master acknowledge sample
  // ******************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxsh <= 8'h00;
      acked <= 1'b0;
    end else if (scl_rise) begin
      rxsh <= {rxsh[6:0], sda_f};
      acked <= ~sda_f;
    end
  end

  // ******************************************************
  // data line drive: acknowledge and transmit bits
  // ******************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
      txsh <= 8'h00;
    end else if (start_ev || stop_ev) begin
      sda_oe_n <= 1'b1;
    end else if ((addr_done && addr_match) || wload || wr_now) begin
      sda_oe_n <= 1'b0;
    end else if ((state == st_ack && scl_fall && rw) || rd_next) begin
      txsh <= regs[tx_ptr] << 1;
      sda_oe_n <= regs[tx_ptr][7];
    end else if (state == st_tx && scl_fall && !byte_end) begin
      sda_oe_n <= txsh[7];
      txsh <= txsh << 1;
    end else if (scl_fall || rd_stop) begin
      sda_oe_n <= 1'b1;
    end
  end

  // ******************************************************
  // clock stretch while the update buffer is full
  // ******************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_oe_n <= 1'b1;
      scl_out <= 1'b0;
    end else begin
      scl_oe_n <= ~((rx_done && !waddr_phase && !fifo_ready) ||
                    (state == st_hold && !fifo_ready));
    end
  end

  // ******************************************************
  // address pointer
  // ******************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr <= PTR_RESET;
    end else if (wload) begin
      ptr <= rxsh[PTR_W-1:0];
    end else if (wr_now || rd_next) begin
      ptr <= ptr + 3'h1;
    end
  end

  // ******************************************************
  // calendar and control locations
  // ******************************************************
  genvar i;
  generate
    for (i = 0; i < NUM_REGS; i++) begin : g_reg
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          regs[i] <= (PTR_W'(i) == CONTROL_INDEX) ?
                     CONTROL_REG_RESET : CLOCK_REG_RESET;
        end else if (wr_now && ptr == PTR_W'(i)) begin
          regs[i] <= rxsh;
        end
      end
      assign reg_image[8*i +: 8] = regs[i];
    end
  endgenerate

  // ******************************************************
  // update stream buffer
  // ******************************************************
  upd_fifo #(.WIDTH(UPD_W), .DEPTH(UPD_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(wr_now),
    .in_ready(fifo_ready),
    .in_data({ptr, rxsh}),
    .out_valid(upd_valid),
    .out_ready(upd_ready),
    .out_data({upd_addr, upd_data})
  );

  // ******************************************************
  // checks
  // ******************************************************
  chk_idle_release: assert property (@(posedge clk) disable iff (rst)
    (state == st_idle || state == st_skip) && !$past(addr_done) |->
      sda_oe_n) else $error("data line driven while idle");
  chk_addr_mismatch: assert property (@(posedge clk) disable iff (rst)
    addr_done && !addr_match && !start_ev |=>
      state == st_skip && sda_oe_n) else $error("foreign address answered");
  chk_addr_ack: assert property (@(posedge clk) disable iff (rst)
    addr_done && addr_match && !start_ev |=>
      state == st_ack && !sda_oe_n) else $error("own address not acked");
  chk_ack_held: assert property (@(posedge clk) disable iff (rst)
    state == st_ack && scl_f |-> !sda_oe_n && !sda_out)
    else $error("ack released during clock high");
  chk_drive_clock_low: assert property (@(posedge clk)
    disable iff (rst) $changed(sda_oe_n) && !$past(start_ev || stop_ev) |->
      !$past(scl_f)) else $error("data changed with clock high");
  chk_start_frame: assert property (@(posedge clk) disable iff (rst)
    start_ev |=> state == st_addr && cnt == 4'h0 && sda_oe_n)
    else $error("start not taken");
  chk_stop_frame: assert property (@(posedge clk) disable iff (rst)
    stop_ev |=> state == st_idle ##1 sda_oe_n)
    else $error("stop not taken");
  chk_ptr_step: assert property (@(posedge clk) disable iff (rst)
    (wr_now || rd_next) && !wload |=> ptr == $past(ptr) + 3'h1)
    else $error("pointer did not step");
  chk_ptr_load: assert property (@(posedge clk) disable iff (rst)
    wload |=> ptr == $past(rxsh[PTR_W-1:0]))
    else $error("word address not loaded");
  chk_read_hold: assert property (@(posedge clk) disable iff (rst)
    state == st_tx |=> ptr == $past(ptr))
    else $error("pointer moved during read byte");
  chk_nack_release: assert property (@(posedge clk) disable iff (rst)
    rd_stop && !start_ev |=> sda_oe_n [*2])
    else $error("data line held after nack");
  cov_write: cover property (@(posedge clk) disable iff (rst) wr_now);
  cov_read_ack: cover property (@(posedge clk) disable iff (rst) rd_next);
  cov_mismatch: cover property (@(posedge clk) disable iff (rst)
    addr_done && !addr_match);
  cov_stretch: cover property (@(posedge clk) disable iff (rst)
    state == st_hold);

endmodule
`default_nettype wire

// ### rtc_two_wire_slave_port_tb.sv
// self-checking bench for the two-wire slave port
// assumes the partner master model and the design files compiled first
`timescale 1ns/10ps
`default_nettype none
module rtc_two_wire_slave_port_tb;
  import rtc_port_pkg::*;
  typedef struct {
    logic [PTR_W-1:0] addr;
    logic [7:0] data;
  } row_type;
  logic clk, rst, upd_ready, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic upd_valid, scl_drv, sda_drv;
  logic [PTR_W-1:0] upd_addr, ptr;
  logic [7:0] upd_data;
  logic [8*NUM_REGS-1:0] reg_image;
  logic [7:0] img [NUM_REGS];
  logic [UPD_W-1:0] got_q [$];
  logic [UPD_W-1:0] exp_q [$];
  wire logic scl_line, sda_line;
  int fail_count = 0;
  int checks_done = 0;
  logic ack;
  int n;
  row_type rows [8] = '{'{3'h0, 8'h59}, '{3'h1, 8'h45}, '{3'h2, 8'h23},
    '{3'h3, 8'h07}, '{3'h4, 8'h31}, '{3'h5, 8'h12}, '{3'h6, 8'h99},
    '{3'h7, 8'h00}};

  // ********
  // wiring
  // ********
  // wired-and of both parties, pull-up when released
  assign scl_line = scl_drv & (scl_oe_n | scl_out);
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  rtc_two_wire_slave_port DUT (.clk(clk), .rst(rst), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .upd_valid(upd_valid),
    .upd_ready(upd_ready), .upd_addr(upd_addr), .upd_data(upd_data),
    .reg_image(reg_image));

  bus_master_model m (.clk(clk), .scl_line(scl_line), .sda_line(sda_line),
    .scl_drv(scl_drv), .sda_drv(sda_drv));

  // clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // records every word taken from the update stream
  always @(posedge clk) begin
    if (upd_valid === 1'b1 && upd_ready === 1'b1) begin
      got_q.push_back({upd_addr, upd_data});
    end
  end

  // ********
  // compare and end
  // ********
  task check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task check_upd(input logic [UPD_W-1:0] got, input logic [UPD_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("checks %0d fails %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ********
  // bus sequences
  // ********
  // write k bytes base+i from word address wa, no stop
  task write_bytes(input logic [PTR_W-1:0] wa, input int k,
                   input logic [7:0] base);
    m.start();
    m.send_byte({DEV_ADDR, 1'b0}, ack);
    check_bit(ack, 1'b1);
    m.send_byte({5'h00, wa}, ack);
    check_bit(ack, 1'b1);
    ptr = wa;
    for (int i = 0; i < k; i++) begin
      m.send_byte(base + 8'(i), ack);
      check_bit(ack, 1'b1);
      img[ptr] = base + 8'(i);
      exp_q.push_back({ptr, base + 8'(i)});
      ptr = ptr + 1'b1; // wraps after control
    end
  endtask

  // read k bytes, optionally after a word address
  task read_bytes(input logic use_wa, input logic [PTR_W-1:0] wa,
                  input int k);
    logic [7:0] d;
    if (use_wa) begin
      m.start();
      m.send_byte({DEV_ADDR, 1'b0}, ack);
      check_bit(ack, 1'b1);
      m.send_byte({5'h00, wa}, ack);
      check_bit(ack, 1'b1);
      ptr = wa;
    end
    m.start();
    m.send_byte({DEV_ADDR, 1'b1}, ack);
    check_bit(ack, 1'b1);
    for (int i = 0; i < k; i++) begin
      m.recv_byte(i < k - 1, d);
      check_byte(d, img[ptr]);
      if (i < k - 1) begin
        ptr = ptr + 1'b1;
      end
    end
    fork
      m.stop();
      begin
        repeat (6) @(negedge clk);
        check_bit(sda_oe_n, 1'b1); // silent after withheld ack
      end
    join
  endtask

  // compare the whole register image and the update stream
  task check_all;
    for (int i = 0; i < NUM_REGS; i++) begin
      check_byte(reg_image[8*i +: 8], img[i]);
    end
    n = 0;
    while (got_q.size() < exp_q.size() && n < 500) begin
      @(negedge clk);
      n++;
    end
    while (exp_q.size() > 0) begin
      check_upd(got_q.size() > 0 ? got_q.pop_front() : 'x,
                exp_q.pop_front());
    end
  endtask

  // ********
  // tests
  // ********
  initial begin
    rst = 1'b1;
    upd_ready = 1'b1;
    foreach (img[i]) img[i] = CLOCK_REG_RESET;
    img[CONTROL_INDEX] = CONTROL_REG_RESET;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    check_bit(sda_oe_n, 1'b1);
    check_bit(scl_oe_n, 1'b1);
    check_bit(upd_valid, 1'b0);
    check_all();
    ptr = PTR_RESET;
    repeat (4) @(negedge clk);
    read_bytes(1'b0, 3'h0, 2); // from reset pointer
    $display("test reset done");
    // ordinary single-byte writes, one row each
    foreach (rows[r]) begin
      write_bytes(rows[r].addr, 1, rows[r].data);
      m.stop();
      check_all();
    end
    $display("test rows done");
    // fill the stream buffer, stretch on the ninth byte
    upd_ready = 1'b0;
    write_bytes(3'h6, 8, 8'h20);
    fork
      m.send_byte(8'h28, ack);
      begin
        n = 0;
        while (scl_oe_n !== 1'b0 && n < 300) begin
          @(negedge clk);
          n++;
        end
        check_bit(scl_oe_n, 1'b0);
        check_bit(upd_valid, 1'b1);
        repeat (10) @(negedge clk);
        upd_ready = 1'b1;
      end
    join
    check_bit(ack, 1'b1);
    img[ptr] = 8'h28;
    exp_q.push_back({ptr, 8'h28});
    ptr = ptr + 1'b1;
    m.stop();
    check_all();
    $display("test burst done");
    read_bytes(1'b1, 3'h5, 3);
    read_bytes(1'b0, 3'h0, 2); // wraps from control
    $display("test read done");
    // foreign address is ignored until the next start
    m.start();
    m.send_byte(8'ha0, ack);
    check_bit(ack, 1'b0);
    m.send_byte(8'h00, ack);
    check_bit(ack, 1'b0);
    m.stop();
    check_all();
    $display("test foreign done");
    test_done();
  end

  // watchdog against a hung bus
  initial begin
    #1000000;
    fail_count++;
    test_done();
  end
endmodule
`default_nettype wire

// ### upd_fifo.sv
// shift-register fifo; head entry and flags are flip-flops
// assumes one clock; push only while in_ready, pop only while out_valid
`timescale 1ns/10ps
`default_nettype none
module upd_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input wire logic clk,                // system clock
  input wire logic rst,                // async reset, high
  input wire logic in_valid,           // push request
  output logic in_ready,               // room for one word
  input wire logic [WIDTH-1:0] in_data, // word pushed
  output logic out_valid,              // head holds a word
  input wire logic out_ready,          // consumer takes head
  output logic [WIDTH-1:0] out_data    // head word
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic [CW-1:0] wpos;
  logic push;
  logic pop;

  // ******************************************************
  // handshakes and fill level
  // ******************************************************
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign next_count = count + CW'(push) - CW'(pop);
  assign wpos = pop ? count - CW'(1) : count;
  assign in_ready = ~vld[DEPTH-1];
  assign out_valid = vld[0];
  assign out_data = mem[0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ******************************************************
  // per-entry storage, shifts toward the head on pop
  // ******************************************************
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem[i] <= '0;
          vld[i] <= 1'b0;
        end else begin
          vld[i] <= (CW'(i) < next_count);
          if (push && wpos == CW'(i)) begin
            mem[i] <= in_data;
          end else if (pop && i < DEPTH - 1) begin
            mem[i] <= mem[(i < DEPTH - 1) ? i + 1 : i];
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire
